// ===== rtl/pwm_ctrl_pkg.sv
// Shared constants and types for the PWM channel control port
package pwm_ctrl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN   = 3;    // Independent PWM channels
  localparam int unsigned PROG_DEPTH = 64;   // Instructions per channel
  localparam int unsigned INSTR_W    = 16;   // Instruction width
  localparam int unsigned CMD_MSB    = 15;   // Top of the command field
  localparam int unsigned CMD_LSB    = 13;   // Bottom of the command field

  // ----------------------------------------------------------------
  // Register map (link register pointer values)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h30;  // pwm_control_status
  localparam logic [7:0] ADDR_INSTR_CH0   = 8'h38;  // pwm_instr_port_ch0
  localparam logic [7:0] ADDR_INSTR_CH1   = 8'h39;  // pwm_instr_port_ch1
  localparam logic [7:0] ADDR_INSTR_CH2   = 8'h3A;  // pwm_instr_port_ch2
  localparam logic [7:0] CTRL_RESET       = 8'h00;  // Control/status reset value
  localparam logic [7:0] READ_ZERO        = 8'h00;  // Unmapped or locked reads

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int unsigned RUN_LSB   = 0;     // chan0_run..chan2_run
  localparam int unsigned BAD_LSB   = 3;     // chan0..chan2_bad_instr
  localparam int unsigned TRIG_ON   = 6;     // ext_trigger_on
  localparam int unsigned TRIG_DIR  = 7;     // ext_trigger_dir

  // ----------------------------------------------------------------
  // Link framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;    // Last data bit of a byte
  localparam logic [3:0] BIT_ACK  = 4'h8;    // Acknowledge bit slot

  // Link transaction phases
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WDATA, PH_RDATA} link_phase_t;

  // Request handed from the link domain to the system domain
  typedef struct packed {
    logic [7:0] addr;  // Register pointer addressed
    logic [7:0] data;  // Write byte
    logic       wr;    // Write (1) or read fetch (0)
    logic       adv;   // Read fetch consumed the previous byte
  } link_req_t;

endpackage

// ===== rtl/pwm_channel_control_port.sv
// PWM channel control port: link slave, control/status and program memories
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Three channels; unused PWM pins act as GPIO
// - Host-loaded instructions are stored in program memory
// - Control/status at 0x30, pointer auto-increments
// - Instruction ports 0x38-0x3A keep the pointer fixed
// - Bits 0-2 enable channels; zero holds reset
// - Instruction port accepted only while channel reset
// - Bits 3-5 flag invalid command, force reset
// - Zero flag means no invalid command met
// - Bit 6 enables external triggering
// - Triggering takes over general-purpose line fifteen
// - Bit 7: high-active input or low-active output
// - 64 instructions of 16 bits per channel
module pwm_channel_control_port
  import pwm_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h42    // Link device address
)(
  input  wire logic                                   clk_i,          // System clock
  input  wire logic                                   rst_n_i,        // Async reset, low
  input  wire logic                                   scl_i,          // Link clock pin
  input  wire logic                                   sda_i,          // Link data pin in
  output logic                                        sda_o,          // Link data pin out
  output logic                                        sda_oe_n_o,     // Link data enable, low
  output logic [pwm_ctrl_pkg::NUM_CHAN-1:0]           chan_run_o,     // Channel enables
  input  wire logic [pwm_ctrl_pkg::NUM_CHAN-1:0]      bad_instr_i,    // Engine met bad command
  input  wire logic [pwm_ctrl_pkg::NUM_CHAN-1:0][5:0] prog_addr_i,    // Engine fetch address
  output logic [pwm_ctrl_pkg::NUM_CHAN-1:0][15:0]     prog_data_o,    // Engine fetch data
  input  wire logic [pwm_ctrl_pkg::NUM_CHAN-1:0]      pwm_level_i,    // Engine PWM level
  input  wire logic [pwm_ctrl_pkg::NUM_CHAN-1:0]      pwm_use_i,      // Pin used for PWM
  input  wire logic [pwm_ctrl_pkg::NUM_CHAN-1:0]      gpio_out_i,     // GPIO level otherwise
  output logic [pwm_ctrl_pkg::NUM_CHAN-1:0]           pwm_pin_o,      // Channel pin level
  input  wire logic                                   trig_fire_i,    // Engine sends trigger
  output logic                                        ext_trig_o,     // Trigger seen at line
  input  wire logic                                   trig_pin_i,     // Trigger line in
  output logic                                        trig_pin_o,     // Trigger line out
  output logic                                        trig_pin_oe_n_o // Trigger enable, low
);
  import pwm_ctrl_pkg::*;

  if (DEV_ADDR == 7'h00)
  begin : g_bad_addr
    $error("Device address zero is the general call");
  end

  // ----------------------------------------------------------------
  // Shared decoding
  // ----------------------------------------------------------------
  // Returns 1 and the channel when the pointer is an instruction port
  function automatic logic [2:0] instr_port(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a == ADDR_INSTR_CH0)
      r = 3'h4;
    else if (a == ADDR_INSTR_CH1)
      r = 3'h5;
    else if (a == ADDR_INSTR_CH2)
      r = 3'h6;
    return r;
  endfunction

  // Pointer after an access: data ports stay put, others step
  function automatic logic [7:0] next_ptr(input logic [7:0] a);
    logic [7:0] r;
    r = a + 8'h01;
    if (instr_port(a) != 3'h0)
      r = a;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Link domain: start detection
  // ----------------------------------------------------------------
  logic        start_tog_q;   // Flips on every start condition
  logic        start_seen_q;  // Last start handled on the link clock

  // Data falling while the clock is high marks a start
  always_ff @(negedge sda_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_tog_q <= 1'b0;
    else if (scl_i)
      start_tog_q <= ~start_tog_q;
  end

  // ----------------------------------------------------------------
  // Link domain: receive side, sampled on the rising link clock
  // ----------------------------------------------------------------
  link_phase_t phase_q;       // Transaction phase
  logic [3:0]  bit_q;         // Bit slot within a byte, 8 = acknowledge
  logic [7:0]  shift_q;       // Incoming byte
  logic [7:0]  ptr_q;         // Register pointer
  logic        ack_q;         // Slave acknowledges the current byte
  link_req_t   req_q;         // Request to the system domain
  logic        req_tog_q;     // Flips once per request
  logic [7:0]  byte_in;       // Byte completed on this edge

  assign byte_in = {shift_q[6:0], sda_i};

  // Byte assembly and request issue; a stop needs no handling since
  // the link clock stands still until the next start re-frames
  always_ff @(posedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_seen_q <= 1'b0;
      phase_q      <= PH_IDLE;
      bit_q        <= 4'h0;
      shift_q      <= 8'h00;
      ptr_q        <= 8'h00;
      ack_q        <= 1'b0;
      req_q        <= '0;
      req_tog_q    <= 1'b0;
    end
    else if (start_tog_q != start_seen_q)
    begin
      // First address bit arrives on the edge after a start
      start_seen_q <= start_tog_q;
      phase_q      <= PH_ADDR;
      bit_q        <= 4'h1;
      shift_q      <= {7'h00, sda_i};
      ack_q        <= 1'b0;
    end
    else if (phase_q != PH_IDLE)
    begin
      if (bit_q == BIT_ACK)
      begin
        bit_q <= 4'h0;
        // Controller not acknowledging ends a read
        if (phase_q == PH_RDATA && sda_i)
          phase_q <= PH_IDLE;
      end
      else
      begin
        shift_q <= byte_in;
        bit_q   <= bit_q + 4'h1;
        if (bit_q == BIT_LAST)
        begin
          case (phase_q)
            PH_ADDR:
            begin
              if (byte_in[7:1] != DEV_ADDR)
              begin
                phase_q <= PH_IDLE;     // Not ours, stay silent
                ack_q   <= 1'b0;
              end
              else if (byte_in[0])
              begin
                phase_q   <= PH_RDATA;  // Fetch the byte at the pointer
                ack_q     <= 1'b1;
                req_q     <= '{addr: ptr_q, data: 8'h00, wr: 1'b0, adv: 1'b0};
                req_tog_q <= ~req_tog_q;
              end
              else
              begin
                phase_q <= PH_PTR;
                ack_q   <= 1'b1;
              end
            end
            PH_PTR:
            begin
              ptr_q     <= byte_in;
              phase_q   <= PH_WDATA;
              ack_q     <= 1'b1;
              // Prefetch so a following read has its byte ready
              req_q     <= '{addr: byte_in, data: 8'h00, wr: 1'b0, adv: 1'b0};
              req_tog_q <= ~req_tog_q;
            end
            PH_WDATA:
            begin
              ack_q     <= 1'b1;
              ptr_q     <= next_ptr(ptr_q);
              req_q     <= '{addr: ptr_q, data: byte_in, wr: 1'b1, adv: 1'b0};
              req_tog_q <= ~req_tog_q;
            end
            PH_RDATA:
            begin
              // Byte sent: consume it and fetch the next one
              ack_q     <= 1'b0;
              ptr_q     <= next_ptr(ptr_q);
              req_q     <= '{addr: next_ptr(ptr_q), data: 8'h00, wr: 1'b0, adv: 1'b1};
              req_tog_q <= ~req_tog_q;
            end
            default:
              phase_q <= PH_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: transmit side, driven on the falling link clock
  // ----------------------------------------------------------------
  logic [7:0] rd_byte_q;      // Fetched byte, system domain
  logic [7:0] tx_q;           // Byte being sent
  logic       oe_n_q;         // Data line release (1) or pull low (0)

  // The fetched byte settled long before the first data slot, so it
  // is read here as a quasi-static word
  always_ff @(negedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_q   <= 8'h00;
      oe_n_q <= 1'b1;
    end
    else if (bit_q == BIT_ACK)
      oe_n_q <= ~ack_q;                 // Pull low to acknowledge
    else if (phase_q == PH_RDATA && bit_q == 4'h0)
    begin
      tx_q   <= rd_byte_q;
      oe_n_q <= rd_byte_q[7];           // MSB first, release for one
    end
    else if (phase_q == PH_RDATA)
      oe_n_q <= tx_q[3'(BIT_LAST - bit_q)];
    else
      oe_n_q <= 1'b1;
  end

  assign sda_o      = 1'b0;             // Open drain: only ever pulls low
  assign sda_oe_n_o = oe_n_q;

  // ----------------------------------------------------------------
  // System domain: request crossing
  // ----------------------------------------------------------------
  logic req_s1_q;             // First synchroniser stage
  logic req_s2_q;             // Second synchroniser stage
  logic req_s3_q;             // Edge reference
  logic req_fire;             // One request to serve

  // Toggle crossing; the request word holds still for a whole byte
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  assign req_fire = req_s2_q ^ req_s3_q;

  // ----------------------------------------------------------------
  // System domain: control/status register
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0] run_q;     // chan0_run..chan2_run
  logic [NUM_CHAN-1:0] bad_q;     // chan0..chan2_bad_instr
  logic                trig_on_q; // ext_trigger_on
  logic                trig_dir_q;// ext_trigger_dir
  logic                ctrl_wr;   // Control/status write this cycle

  assign ctrl_wr = req_fire && req_q.wr && req_q.addr == ADDR_CTRL_STATUS;

  // Enables and trigger setup; a bad command outranks a host write
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_q      <= CTRL_RESET[RUN_LSB +: NUM_CHAN];
      trig_on_q  <= CTRL_RESET[TRIG_ON];
      trig_dir_q <= CTRL_RESET[TRIG_DIR];
    end
    else
    begin
      if (ctrl_wr)
      begin
        trig_on_q  <= req_q.data[TRIG_ON];
        trig_dir_q <= req_q.data[TRIG_DIR];
      end
      run_q <= (ctrl_wr ? req_q.data[RUN_LSB +: NUM_CHAN] : run_q)
               & ~bad_instr_i;
    end
  end

  // Invalid flags: set wins, cleared when the host restarts the channel
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bad_q <= CTRL_RESET[BAD_LSB +: NUM_CHAN];
    else if (ctrl_wr)
      bad_q <= bad_instr_i | (bad_q & ~req_q.data[RUN_LSB +: NUM_CHAN]);
    else
      bad_q <= bad_q | bad_instr_i;
  end

  assign chan_run_o = run_q;

  // ----------------------------------------------------------------
  // System domain: per-channel program memory and load index
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0][6:0] idx_q;    // Byte index into the program
  logic [NUM_CHAN-1:0][6:0] idx_d;    // Index after this request
  logic [NUM_CHAN-1:0][7:0] peek;     // Byte at the updated index

  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    logic [INSTR_W-1:0] mem [PROG_DEPTH];
    logic               hit;                // Request names this port
    logic               load;               // Byte stored this cycle
    logic [INSTR_W-1:0] word;               // Word at the updated index

    assign hit  = req_fire && instr_port(req_q.addr) == {1'b1, 2'(c)};
    assign load = hit && req_q.wr && !run_q[c];

    // Writes and consumed reads step the byte index while in reset
    always_comb
    begin
      idx_d[c] = idx_q[c];
      if (hit && !run_q[c] && (req_q.wr || req_q.adv))
        idx_d[c] = idx_q[c] + 7'h01;
    end

    assign word    = mem[idx_d[c][6:1]];
    assign peek[c] = idx_d[c][0] ? word[7:0] : word[CMD_MSB:8];

    // Index restarts from the first MSB whenever the channel runs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        idx_q[c] <= 7'h00;
      else if (run_q[c])
        idx_q[c] <= 7'h00;
      else
        idx_q[c] <= idx_d[c];
    end

    // Even byte is the high half, odd byte the low half
    always_ff @(posedge clk_i)
    begin
      if (load && !idx_q[c][0])
        mem[idx_q[c][6:1]][CMD_MSB:8] <= req_q.data;
      else if (load)
        mem[idx_q[c][6:1]][7:0] <= req_q.data;
    end

    // Engine fetch port, one cycle of latency
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        prog_data_o[c] <= '0;
      else
        prog_data_o[c] <= mem[prog_addr_i[c]];
    end
  end

  // ----------------------------------------------------------------
  // System domain: read data for the link
  // ----------------------------------------------------------------
  // Fetch result; a running channel reads back as zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_byte_q <= READ_ZERO;
    else if (req_fire && !req_q.wr)
    begin
      if (req_q.addr == ADDR_CTRL_STATUS)
        rd_byte_q <= {trig_dir_q, trig_on_q, bad_q, run_q};
      else if (instr_port(req_q.addr) != 3'h0 && !run_q[2'(instr_port(req_q.addr))])
        rd_byte_q <= peek[2'(instr_port(req_q.addr))];
      else
        rd_byte_q <= READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Pins: trigger line and channel outputs
  // ----------------------------------------------------------------
  logic trig_s1_q;            // First synchroniser stage
  logic trig_s2_q;            // Second synchroniser stage

  // Trigger line takes over the GPIO when enabled
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trig_s1_q       <= 1'b0;
      trig_s2_q       <= 1'b0;
      ext_trig_o      <= 1'b0;
      trig_pin_o      <= 1'b1;
      trig_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      trig_s1_q       <= trig_pin_i;
      trig_s2_q       <= trig_s1_q;
      ext_trig_o      <= trig_on_q && !trig_dir_q && trig_s2_q;
      trig_pin_o      <= ~trig_fire_i;
      trig_pin_oe_n_o <= ~(trig_on_q && trig_dir_q);
    end
  end

  // Channel pin carries PWM when used, else the GPIO level
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pwm_pin_o <= '0;
    else
      pwm_pin_o <= (pwm_use_i & pwm_level_i) | (~pwm_use_i & gpio_out_i);
  end

endmodule
`default_nettype wire

// ===== tb/pwm_ctrl_checker_properties.sv
// Concurrent checks on the ports of the PWM channel control port
`timescale 1ns/10ps
`default_nettype none
module pwm_ctrl_checker
  import pwm_ctrl_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                scl_i,
  input wire logic                sda_o,
  input wire logic                sda_oe_n_o,
  input wire logic [NUM_CHAN-1:0] chan_run_o,
  input wire logic [NUM_CHAN-1:0] bad_instr_i,
  input wire logic [NUM_CHAN-1:0] pwm_level_i,
  input wire logic [NUM_CHAN-1:0] pwm_use_i,
  input wire logic [NUM_CHAN-1:0] gpio_out_i,
  input wire logic [NUM_CHAN-1:0] pwm_pin_o,
  input wire logic                trig_fire_i,
  input wire logic                ext_trig_o,
  input wire logic                trig_pin_i,
  input wire logic                trig_pin_o,
  input wire logic                trig_pin_oe_n_o
);
  // ----------------------------------------------------------------
  // Everything is judged on the system clock
  // ----------------------------------------------------------------
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_bad_clears_run: assert property (|bad_instr_i |=>
    (chan_run_o & $past(bad_instr_i)) == 3'h0) else $error("run bit kept after bad command");
  a_pin_select: assert property ($past(rst_n_i) |-> pwm_pin_o ==
    (($past(pwm_use_i) & $past(pwm_level_i)) | (~$past(pwm_use_i) & $past(gpio_out_i))))
    else $error("pin level not use ? level : gpio");
  a_trig_out_low: assert property ($past(rst_n_i) |-> trig_pin_o == !$past(trig_fire_i))
    else $error("trigger output not active low");
  a_output_blinds_input: assert property (!trig_pin_oe_n_o && $past(!trig_pin_oe_n_o)
    |-> !ext_trig_o) else $error("trigger seen while line is an output");
  a_trig_sync_in: assert property ($rose(ext_trig_o) |->
    $past(trig_pin_i, 2) || $past(trig_pin_i, 3) || $past(trig_pin_i, 4))
    else $error("trigger seen without a high line");
  a_reset_values: assert property ($rose(rst_n_i) |-> chan_run_o == 3'h0
    && trig_pin_oe_n_o && sda_oe_n_o && !ext_trig_o) else $error("bad state after reset");
  a_sda_falling_only: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data enable moved while link clock high");
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");

  // Main scenarios reached
  c_bad_hit: cover property (|(bad_instr_i & chan_run_o));
  c_trig_in: cover property ($rose(ext_trig_o));
  c_run_two: cover property ($rose(chan_run_o[2]));
endmodule

bind pwm_channel_control_port pwm_ctrl_checker u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .chan_run_o(chan_run_o), .bad_instr_i(bad_instr_i), .pwm_level_i(pwm_level_i),
  .pwm_use_i(pwm_use_i), .gpio_out_i(gpio_out_i), .pwm_pin_o(pwm_pin_o),
  .trig_fire_i(trig_fire_i), .ext_trig_o(ext_trig_o), .trig_pin_i(trig_pin_i),
  .trig_pin_o(trig_pin_o), .trig_pin_oe_n_o(trig_pin_oe_n_o));
`default_nettype wire

// ===== tb/i2c_host_model.sv
// Behavioural link controller standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  output logic      scl_o,  // Link clock, idle high between frames
  output logic      sda_o,  // Data drive, 1 releases to the pull-up
  input  wire logic sda_i   // Resolved data line
);
  localparam time HALF = 24;  // Half of the 48 ns link period
  time low_extra = 0;         // Stretches low phases for a slow host

  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Start or repeated start; odd offset keeps link edges off system edges
  task automatic frame_start();
    #3.3 sda_o = 1'b1;
    #HALF scl_o = 1'b1;
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask

  // Stop; clock then stands still high
  task automatic frame_stop();
    #2 sda_o = 1'b0;
    #(HALF - 2) scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask

  // One byte out, most significant bit first, then the acknowledge slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #2 sda_o = b[i];  // Changed only while clock low
      #(HALF - 2 + low_extra) scl_o = 1'b1;
      #HALF scl_o = 1'b0;
    end
    #2 sda_o = 1'b1;
    #(HALF - 2 + low_extra) scl_o = 1'b1;
    ack = ~sda_i;
    #HALF scl_o = 1'b0;
  endtask

  // One byte in; ack low asks for more, high ends the read
  task automatic recv_byte(input logic more, output logic [7:0] b);
    #2 sda_o = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      #(HALF - 2 + low_extra) scl_o = 1'b1;
      b[i] = sda_i;
      #HALF scl_o = 1'b0;
      #2;
    end
    sda_o = ~more;
    #(HALF - 2 + low_extra) scl_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the PWM channel control port
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pwm_ctrl_pkg::*;
  localparam logic [7:0] DEV_WR = 8'h84;  // Default device address, write
  localparam logic [7:0] DEV_RD = 8'h85;  // Same, read
  logic                clk = 1'b0, rst_n = 1'b1, scl, host_sda, sda_out, sda_oe_n;
  logic [2:0]          chan_run, pwm_pin, bad_instr = '0, pwm_level = '0;
  logic [2:0]          pwm_use = '0, gpio_out = '0;
  logic [2:0][5:0]     prog_addr = '0;
  logic [2:0][15:0]    prog_data;
  logic                trig_fire = 1'b0, trig_drv = 1'b0, ext_trig, trig_out, trig_oe_n;
  wire                 sda_line = host_sda & (sda_oe_n | sda_out);  // Pull-up
  wire                 trig_line = trig_oe_n ? trig_drv : trig_out;
  int                  failures = 0, samples_checked = 0;

  always #4 clk = ~clk;

  i2c_host_model u_host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_line));

  pwm_channel_control_port u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_out),
    .sda_oe_n_o(sda_oe_n), .chan_run_o(chan_run), .bad_instr_i(bad_instr),
    .prog_addr_i(prog_addr), .prog_data_o(prog_data), .pwm_level_i(pwm_level),
    .pwm_use_i(pwm_use), .gpio_out_i(gpio_out), .pwm_pin_o(pwm_pin),
    .trig_fire_i(trig_fire), .ext_trig_o(ext_trig), .trig_pin_i(trig_line),
    .trig_pin_o(trig_out), .trig_pin_oe_n_o(trig_oe_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Realign to the stimulus point just after a clock edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Write n bytes taken from the top of d
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input int n);
    logic ack;
    u_host.frame_start();
    u_host.send_byte(DEV_WR, ack);
    chk(ack, 1'b1, "address ack");
    u_host.send_byte(a, ack);
    for (int j = 0; j < n; j++)
    begin
      u_host.send_byte(d[31 - 8*j -: 8], ack);
      chk(ack, 1'b1, "data ack");
    end
    u_host.frame_stop();
    settle(6);
  endtask

  // Read n bytes and compare, right justified
  task automatic rd_chk(input logic [7:0] a, input int n, input logic [31:0] exp,
                        input string what);
    logic       ack;
    logic [7:0] b;
    logic [31:0] d;
    d = '0;
    u_host.frame_start();
    u_host.send_byte(DEV_WR, ack);
    u_host.send_byte(a, ack);
    u_host.frame_start();
    u_host.send_byte(DEV_RD, ack);
    for (int j = 0; j < n; j++)
    begin
      u_host.recv_byte(j < n - 1, b);
      d = {d[23:0], b};
    end
    u_host.frame_stop();
    settle(2);
    chk(d, exp, what);
  endtask

  task automatic prog_chk(input int c, input logic [5:0] w, input logic [15:0] exp);
    prog_addr[c] = w;
    settle(2);
    chk(prog_data[c], exp, "program word");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ctrl_map();
    logic ack;
    rd_chk(ADDR_CTRL_STATUS, 1, 32'h00, "status after reset");
    u_host.frame_start();
    u_host.send_byte(8'h90, ack);
    u_host.frame_stop();
    chk(ack, 1'b0, "foreign address acked");
    reg_wr(ADDR_CTRL_STATUS, 32'h053F_0000, 2);  // Second byte lands on 0x31
    chk(chan_run, 3'b101, "run bits");
    rd_chk(ADDR_CTRL_STATUS, 2, 32'h0500, "pointer steps");
  endtask

  task automatic t_load();
    logic [7:0] c8;
    reg_wr(ADDR_CTRL_STATUS, 32'h0000_0000, 1);  // Host holds all in reset
    for (int c = 0; c < 3; c++)
    begin
      c8 = 8'(c);
      u_host.low_extra = (c == 2) ? 40 : 0;
      reg_wr(ADDR_INSTR_CH0 + c8, {8'hA0 + c8, 8'h1B, 8'hC2, 8'hD3 + c8}, 4);
      prog_chk(c, 6'd0, {8'hA0 + c8, 8'h1B});
      prog_chk(c, 6'd1, {8'hC2, 8'hD3 + c8});
    end
    u_host.low_extra = 0;
    reg_wr(ADDR_CTRL_STATUS, 32'h0700_0000, 1);  // Running restarts each load index
    reg_wr(ADDR_CTRL_STATUS, 32'h0000_0000, 1);
    for (int c = 0; c < 3; c++)
      rd_chk(ADDR_INSTR_CH0 + 8'(c), 4, {8'hA0 + 8'(c), 16'h1BC2, 8'hD3 + 8'(c)}, "port");
    reg_wr(ADDR_CTRL_STATUS, 32'h0200_0000, 1);
    reg_wr(ADDR_INSTR_CH1, 32'hEEEE_0000, 2);
    prog_chk(1, 6'd0, 16'hA11B);
    rd_chk(ADDR_INSTR_CH1, 1, 32'h00, "running port");
  endtask

  task automatic t_bad();
    reg_wr(ADDR_CTRL_STATUS, 32'h0700_0000, 1);
    bad_instr = 3'b100;
    settle(1);
    bad_instr = 3'b000;
    settle(1);
    chk(chan_run, 3'b011, "bad command run");
    rd_chk(ADDR_CTRL_STATUS, 1, 32'h23, "bad flag");
    reg_wr(ADDR_CTRL_STATUS, 32'h3F00_0000, 1);  // Flags read-only, run clears them
    rd_chk(ADDR_CTRL_STATUS, 1, 32'h07, "flag cleared");
  endtask

  task automatic t_trig();
    reg_wr(ADDR_CTRL_STATUS, 32'h4000_0000, 1);
    trig_drv = 1'b1;
    settle(5);
    chk(ext_trig, 1'b1, "trigger input");
    chk(trig_oe_n, 1'b1, "line released");
    reg_wr(ADDR_CTRL_STATUS, 32'hC000_0000, 1);
    chk(trig_oe_n, 1'b0, "line driven");
    chk(ext_trig, 1'b0, "output not seen");
    trig_fire = 1'b1;
    settle(2);
    chk(trig_line, 1'b0, "trigger low");
    trig_fire = 1'b0;
    reg_wr(ADDR_CTRL_STATUS, 32'h0000_0000, 1);
    chk({trig_oe_n, ext_trig}, 2'b10, "trigger off");
  endtask

  task automatic t_pins();
    {pwm_use, pwm_level, gpio_out} = {3'b101, 3'b001, 3'b010};
    settle(2);
    chk(pwm_pin, 3'b011, "pin mux a");
    {pwm_use, pwm_level, gpio_out} = {3'b010, 3'b010, 3'b101};
    settle(2);
    chk(pwm_pin, 3'b111, "pin mux b");
  endtask

  task automatic t_reset_again();
    reg_wr(ADDR_CTRL_STATUS, 32'hC700_0000, 1);
    rst_n = 1'b0;
    settle(2);
    chk({chan_run, trig_oe_n}, 4'b0001, "held in reset");
    rst_n = 1'b1;
    settle(4);
    rd_chk(ADDR_CTRL_STATUS, 1, 32'h00, "status cleared");
  endtask

  initial
  begin
    #1 rst_n = 1'b0;  // Real falling edge fires every async reset
    settle(16);
    rst_n = 1'b1;
    settle(4);
    t_ctrl_map();
    t_load();
    t_bad();
    t_trig();
    t_pins();
    t_reset_again();
    end_sim();
  end

  // Whole run needs well under 200 us of link traffic
  initial
  begin
    #500000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
